// ### rtl/tmcs_top.sv
// timer channel mode control: clock select, clear on match, capture
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module tmcs_top
   import tmcs_pkg::*;
#(
   parameter int CHANNEL_INDEX = 1,
   parameter int COUNT_W = 16,
   parameter int PRESC_W = tmcs_pkg::TAP16_LOG
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic capture_input_pin_0,
   input wire logic capture_input_pin_1,
   input wire logic [15:0] channel_match_outputs,
   output logic match_output
);
   import tmcs_pkg::*;

   // true when this channel has capture input pins
   function automatic logic has_pins(input int ch);
      return !(ch == CH_0 || ch == CH_3 || ch == CH_4 ||
               ch == CH_8 || ch == CH_A);
   endfunction : has_pins

   // which neighbour match output feeds mode 11
   function automatic int match_source(input int ch);
      int grp;
      grp = ch / CH_4;
      return (grp ^ 1) * CH_4;
   endfunction : match_source

   // neighbour exists only for channels off the group head
   localparam logic PINS = has_pins(CHANNEL_INDEX);
   localparam logic SRC_OK = (CHANNEL_INDEX % CH_4) != 0;
   localparam int SRC_CH = match_source(CHANNEL_INDEX);

   // control state
   logic channel_enable_bit; // gates all other registers
   logic count_run; // counter runs
   logic presc_run; // prescaler runs
   tmcs_cpm_t capture_timing_select; // capture mode field
   logic counter_clear_on_match_enable; // clear on compare
   tmcs_clk_t source_clock_select; // counter clock source
   logic [COUNT_W-1:0] compare_register_1; // match value
   logic [COUNT_W-1:0] up_counter; // the count
   logic [COUNT_W-1:0] capture_register_0; // first capture
   logic [COUNT_W-1:0] capture_register_1; // second capture
   logic [PRESC_W-1:0] prescaler; // free divider

   // input synchronisers, three stages each
   logic [1:0] pin_s1;
   logic [1:0] pin_s2;
   logic [1:0] pin_s3;
   logic [1:0] pin_level; // filtered level
   logic [1:0] pin_level_d; // previous filtered level
   logic [1:0] pin_rise;
   logic [1:0] pin_fall;
   // neighbour match, same clock so no synchroniser
   logic nb_match;
   logic nb_match_d;
   logic nb_rise;
   logic nb_fall;

   // bus handshake terms
   logic wr_go; // write taken this cycle
   logic rd_go; // read taken this cycle
   logic [31:0] rd_value; // read mux result
   logic rd_mapped; // read address known
   logic wr_mapped; // write address known
   logic sw_capture; // software capture request
   logic tick; // one counter step
   logic at_match; // counter equals compare
   logic cap0_event;
   logic cap1_event;
   logic active; // channel enabled and counting

   // merge byte lanes into a register
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            res[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return res;
   endfunction : merge

   // both write channels taken together, one response at a time
   assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   // one read at a time
   assign rd_go = s_axi_arvalid && !s_axi_rvalid;
   assign s_axi_arready = !s_axi_rvalid;

   // known write offsets
   always_comb
   begin
      case (s_axi_awaddr)
         OFS_ENABLE, OFS_RUN, OFS_MODE, OFS_COUNT,
         OFS_CMP1, OFS_CAP0, OFS_CAP1: wr_mapped = 1'b1;
         default: wr_mapped = 1'b0;
      endcase
   end

   // software capture: a zero in bit 5 of the low byte
   assign sw_capture = wr_go && channel_enable_bit &&
      s_axi_awaddr == OFS_MODE && s_axi_wstrb[0] &&
      !s_axi_wdata[BIT_SW_CAPTURE];

   // enable register, always reachable
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         channel_enable_bit <= 1'b0;
      else if (wr_go && s_axi_awaddr == OFS_ENABLE && s_axi_wstrb[0])
         channel_enable_bit <= s_axi_wdata[BIT_ENABLE];
   end

   // run register, only while enabled
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         count_run <= 1'b0;
         presc_run <= 1'b0;
      end
      else if (wr_go && channel_enable_bit &&
               s_axi_awaddr == OFS_RUN && s_axi_wstrb[0])
      begin
         count_run <= s_axi_wdata[BIT_RUN];
         presc_run <= s_axi_wdata[BIT_PRESC_RUN];
      end
   end

   // mode register fields
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         capture_timing_select <= tmcs_cpm_t'(CPM_RESET);
         counter_clear_on_match_enable <= 1'b0;
         source_clock_select <= tmcs_clk_t'(CLK_RESET);
      end
      else if (wr_go && channel_enable_bit &&
               s_axi_awaddr == OFS_MODE && s_axi_wstrb[0])
      begin
         capture_timing_select <=
            tmcs_cpm_t'(s_axi_wdata[CPM_LSB +: 2]);
         counter_clear_on_match_enable <=
            s_axi_wdata[BIT_CLEAR_EN];
         source_clock_select <=
            tmcs_clk_t'(s_axi_wdata[CLK_LSB +: 2]);
      end
   end

   // compare register 1, byte lanes honoured
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         compare_register_1 <= CMP1_RESET;
      else if (wr_go && channel_enable_bit &&
               s_axi_awaddr == OFS_CMP1)
         compare_register_1 <= COUNT_W'(merge(
            {{(32-COUNT_W){1'b0}}, compare_register_1},
            s_axi_wdata, s_axi_wstrb));
   end

   // write response; unknown offsets get an error
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end
      else if (wr_go)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // read mux; a disabled channel reads zero except enable
   always_comb
   begin
      rd_value = READ_ZERO;
      rd_mapped = 1'b1;
      case (s_axi_araddr)
         OFS_ENABLE: rd_value[BIT_ENABLE] = channel_enable_bit;
         OFS_RUN:
         begin
            rd_value[BIT_RUN] = count_run;
            rd_value[BIT_PRESC_RUN] = presc_run;
         end
         OFS_MODE:
         begin
            rd_value[BIT_SW_CAPTURE] = 1'b1;
            rd_value[CPM_LSB +: 2] = capture_timing_select;
            rd_value[BIT_CLEAR_EN] = counter_clear_on_match_enable;
            rd_value[CLK_LSB +: 2] = source_clock_select;
         end
         OFS_COUNT: rd_value[COUNT_W-1:0] = up_counter;
         OFS_CMP1: rd_value[COUNT_W-1:0] = compare_register_1;
         OFS_CAP0: rd_value[COUNT_W-1:0] = capture_register_0;
         OFS_CAP1: rd_value[COUNT_W-1:0] = capture_register_1;
         default: rd_mapped = 1'b0;
      endcase
      // no clock to other registers while disabled
      if (!channel_enable_bit && s_axi_araddr != OFS_ENABLE)
         rd_value = READ_ZERO;
   end

   // read data channel
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= READ_ZERO;
         s_axi_rresp <= RESP_OKAY;
      end
      else if (rd_go)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_value;
         s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // pin synchronisers; channels without pins see a low level
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pin_s1 <= 2'h0;
         pin_s2 <= 2'h0;
         pin_s3 <= 2'h0;
      end
      else
      begin
         pin_s1 <= PINS ? {capture_input_pin_1,
                           capture_input_pin_0} : 2'h0;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
      end
   end

   // filtered level moves when stages two and three agree
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pin_level <= 2'h0;
         pin_level_d <= 2'h0;
      end
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            if (pin_s2[i] == pin_s3[i])
               pin_level[i] <= pin_s3[i];
         end
         pin_level_d <= pin_level;
      end
   end

   // pin edges
   assign pin_rise = pin_level & ~pin_level_d;
   assign pin_fall = ~pin_level & pin_level_d;

   // neighbour match output and its edges
   assign nb_match = SRC_OK && channel_match_outputs[SRC_CH];
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         nb_match_d <= 1'b0;
      else
         nb_match_d <= nb_match;
   end
   assign nb_rise = nb_match && !nb_match_d;
   assign nb_fall = !nb_match && nb_match_d;

   // prescaler counts only while its run bit is set
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         prescaler <= '0;
      else if (channel_enable_bit && presc_run)
         prescaler <= PRESC_W'(prescaler + 1'b1);
      else
         prescaler <= '0;
   end

   // counter clock selection
   always_comb
   begin
      case (source_clock_select)
         SRC_PIN0: tick = pin_rise[0];
         SRC_TAP1: tick = presc_run && &prescaler[TAP1_LOG-1:0];
         SRC_TAP4: tick = presc_run && &prescaler[TAP4_LOG-1:0];
         SRC_TAP16: tick = presc_run && &prescaler[TAP16_LOG-1:0];
         default: tick = 1'b0;
      endcase
   end

   assign active = channel_enable_bit && count_run;
   assign at_match = up_counter == compare_register_1;

   // up-counter: step on tick, clear on match when allowed
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         up_counter <= '0;
      else if (active && tick)
      begin
         if (counter_clear_on_match_enable && at_match)
            up_counter <= '0;
         else
            up_counter <= COUNT_W'(up_counter + 1'b1);
      end
   end

   // own match output for neighbouring channels
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         match_output <= 1'b0;
      else
         match_output <= active && at_match;
   end

   // capture events by timing mode
   always_comb
   begin
      cap0_event = 1'b0;
      cap1_event = 1'b0;
      case (capture_timing_select)
         CPM_OFF: cap0_event = 1'b0;
         CPM_PIN0_PIN1:
         begin
            cap0_event = pin_rise[0];
            cap1_event = pin_rise[1];
         end
         CPM_PIN0_BOTH:
         begin
            cap0_event = pin_rise[0];
            cap1_event = pin_fall[0];
         end
         CPM_MATCH:
         begin
            cap0_event = nb_rise;
            cap1_event = nb_fall;
         end
         default: cap0_event = 1'b0;
      endcase
   end

   // capture registers take the current count
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         capture_register_0 <= '0;
         capture_register_1 <= '0;
      end
      else
      begin
         if (sw_capture || (channel_enable_bit && cap0_event))
            capture_register_0 <= up_counter;
         if (channel_enable_bit && cap1_event)
            capture_register_1 <= up_counter;
      end
   end
endmodule : tmcs_top
`default_nettype wire

// ### pkg/tmcs_pkg.sv
// constants for the timer mode, capture and clock-select block
`default_nettype none
package tmcs_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_ENABLE = 8'h00;
   localparam logic [7:0] OFS_RUN = 8'h04;
   localparam logic [7:0] OFS_MODE = 8'h0C;
   localparam logic [7:0] OFS_COUNT = 8'h1C;
   localparam logic [7:0] OFS_CMP1 = 8'h24;
   localparam logic [7:0] OFS_CAP0 = 8'h28;
   localparam logic [7:0] OFS_CAP1 = 8'h2C;
   // field positions
   localparam int BIT_ENABLE = 7;
   localparam int BIT_RUN = 0;
   localparam int BIT_PRESC_RUN = 2;
   localparam int BIT_SW_CAPTURE = 5;
   localparam int BIT_CLEAR_EN = 2;
   localparam int CPM_LSB = 3;
   localparam int CLK_LSB = 0;
   // reset and fixed read values
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;
   localparam logic [1:0] CPM_RESET = 2'h0;
   localparam logic [1:0] CLK_RESET = 2'h0;
   localparam logic [15:0] CMP1_RESET = 16'h0000;
   // bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // prescaler tap positions, log2 of the divide ratio
   localparam int TAP1_LOG = 1;
   localparam int TAP4_LOG = 3;
   localparam int TAP16_LOG = 5;
   // channel numbers, all but CH_C without capture pins
   localparam int CH_0 = 0;
   localparam int CH_3 = 3;
   localparam int CH_4 = 4;
   localparam int CH_8 = 8;
   localparam int CH_A = 10;
   localparam int CH_C = 12;
   // capture timing modes
   typedef enum logic [1:0]
   {
      CPM_OFF = 2'h0,
      CPM_PIN0_PIN1 = 2'h1,
      CPM_PIN0_BOTH = 2'h2,
      CPM_MATCH = 2'h3
   } tmcs_cpm_t;
   // source clock choices
   typedef enum logic [1:0]
   {
      SRC_PIN0 = 2'h0,
      SRC_TAP1 = 2'h1,
      SRC_TAP4 = 2'h2,
      SRC_TAP16 = 2'h3
   } tmcs_clk_t;
endpackage : tmcs_pkg
`default_nettype wire

// ### tb/tmcs_top_asserts.sv
// port checks for the timer mode block
`timescale 1ns/1ps
`default_nettype none
module tmcs_top_asserts
   import tmcs_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic match_output
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // write answered one cycle after take
   wr_answer_a: assert property (s_axi_awvalid && s_axi_awready
      |=> s_axi_bvalid) else $error("write response missing");
   // read answered one cycle after take
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("read response missing");
   // response held until accepted
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
   // no new take while answer pending
   wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write taken while busy");
   rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   // address and data taken together
   aw_w_pair_a: assert property (s_axi_awready |-> s_axi_wready
      && s_axi_awvalid && s_axi_wvalid) else $error("write halves split");
   // unmapped read answers error and zero
   rd_unmapped_a: assert property (s_axi_arvalid && s_axi_arready
      && s_axi_araddr == 8'h40 |=> s_axi_rresp == RESP_SLVERR
      && s_axi_rdata == READ_ZERO) else $error("unmapped read wrong");
   // mode read: upper bits zero, bit 5 reads one unless the whole word reads zero
   mode_read_a: assert property (
      s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_MODE
      |=> s_axi_rdata[31:6] == 26'h0
      && (s_axi_rdata == READ_ZERO || s_axi_rdata[5]))
      else $error("mode readback wrong");
   // main scenarios reached
   slverr_c: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
   match_c: cover property ($rose(match_output));
   read_c: cover property ($rose(s_axi_rvalid));
endmodule : tmcs_top_asserts
`default_nettype wire

// ### tb/tmcs_far_model.sv
// capture pins and neighbour channel match outputs
`timescale 1ns/1ps
`default_nettype none
module tmcs_far_model
(
   input wire logic want_pin_0,
   input wire logic want_pin_1,
   input wire logic [15:0] want_match,
   input wire logic own_match,
   output logic capture_input_pin_0,
   output logic capture_input_pin_1,
   output logic [15:0] channel_match_outputs
);
   // pins follow the bench's requested levels
   assign capture_input_pin_0 = want_pin_0;
   assign capture_input_pin_1 = want_pin_1;
   // channel 1 slot carries our own match output
   always_comb
   begin
      channel_match_outputs = want_match;
      channel_match_outputs[1] = own_match;
   end
endmodule : tmcs_far_model
`default_nettype wire

// ### tb/test_tmcs_top.sv
// self-checking bench for the timer mode block
`timescale 1ns/1ps
`default_nettype none
module test_tmcs_top;
   import tmcs_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [2:0] s_axi_awprot = 3'h0;
   logic [2:0] s_axi_arprot = 3'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   wire logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   wire logic s_axi_arready, s_axi_rvalid, match_output;
   wire logic capture_input_pin_0, capture_input_pin_1;
   wire logic [1:0] s_axi_bresp, s_axi_rresp;
   wire logic [31:0] s_axi_rdata;
   wire logic [15:0] channel_match_outputs;
   wire logic [31:0] np_rdata; // read data of the pinless channel
   logic want_pin_0 = 1'b0; // far side pin levels
   logic want_pin_1 = 1'b0;
   logic [15:0] want_match = 16'h0000; // neighbour matches
   int miscompares = 0;
   int checked = 0;
   int cycles = 0;
   logic [31:0] rd; // last read word
   logic [31:0] np_rd; // last read word of the pinless channel
   logic [1:0] rsp; // last response
   logic [15:0] ca, cb; // counter snapshots
   logic saw; // match output seen

   tmcs_top #(.CHANNEL_INDEX(1)) dut (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .capture_input_pin_0,
      .capture_input_pin_1, .channel_match_outputs, .match_output);
   // pinless channel in lockstep on the same bus and pins
   tmcs_top #(.CHANNEL_INDEX(3)) dut_np (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awprot, .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(),
      .s_axi_bvalid(), .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
      .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(np_rdata),
      .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready, .capture_input_pin_0,
      .capture_input_pin_1, .channel_match_outputs, .match_output());
   tmcs_far_model far (.want_pin_0, .want_pin_1, .want_match,
      .own_match(match_output), .capture_input_pin_0,
      .capture_input_pin_1, .channel_match_outputs);

   // 25 MHz clock
   initial
   begin
      forever #20 aclk = ~aclk;
   end
   // hang guard
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         miscompares++;
         test_done();
      end
   end

   task automatic test_done;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : test_done

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checked++;
      if (seen !== want)
      begin
         miscompares++;
         $display("Error %0t: saw %h expected %h", $time, seen, want);
      end
   endtask : check

   task automatic wait_clk(input int n);
      repeat (n) @(posedge aclk);
   endtask : wait_clk

   // one bus write, address and data offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (s_axi_awready !== 1'b1);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr

   // one bus read into rd and rsp
   task automatic rdw(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      np_rd = np_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rdw

   // run the counter briefly on a mode, leave its value in ca
   task automatic step(input logic [31:0] mode);
      wr(OFS_MODE, mode);
      wr(OFS_RUN, 32'h05);
      wait_clk(20);
      wr(OFS_RUN, 32'h04);
      rdw(OFS_COUNT);
      ca = rd[15:0];
   endtask : step

   // reset values, enable gate, unmapped place
   task automatic t_regs;
      rdw(OFS_MODE);
      check(rd, READ_ZERO);
      wr(OFS_ENABLE, 32'h80);
      rdw(OFS_MODE);
      check(rd, 32'h20);
      rdw(8'h40);
      check({30'h0, rsp}, {30'h0, RESP_SLVERR});
      wr(8'h40, 32'h0);
      check({30'h0, rsp}, {30'h0, RESP_SLVERR});
      wr(OFS_MODE, 32'h07);
      rdw(OFS_MODE);
      check(rd, 32'h27);
   endtask : t_regs

   // each prescaler tap over a 64-clock run window
   task automatic t_rate;
      for (int i = 1; i < 4; i++)
      begin
         step(32'h20 | i);
         wr(OFS_RUN, 32'h05);
         wait_clk(64);
         wr(OFS_RUN, 32'h04);
         rdw(OFS_COUNT);
         cb = rd[15:0] - ca;
         check({31'h0, cb >= (64 >> (2 * i - 1))
            && cb <= (64 >> (2 * i - 1)) + 3}, 32'h1);
         rdw(OFS_COUNT);
         check(rd[15:0], ca + cb);
      end
   endtask : t_rate

   // clear on compare match, then clearing off
   task automatic t_clear;
      wr(OFS_CMP1, {16'h0, ca + 16'h4});
      wr(OFS_MODE, 32'h25);
      wr(OFS_RUN, 32'h05);
      saw = 1'b0;
      for (int n = 0; n < 64; n++)
      begin
         @(posedge aclk);
         saw = saw | (match_output === 1'b1);
      end
      wr(OFS_RUN, 32'h04);
      check({31'h0, saw}, 32'h1);
      rdw(OFS_COUNT);
      check({31'h0, rd[15:0] <= ca + 16'h4}, 32'h1);
      step(32'h21);
      check({31'h0, ca > cb + 16'h4}, 32'h1);
      wr(OFS_CMP1, {16'h0, ca + 16'h2});
      wr(OFS_RUN, 32'h05);
      wait_clk(20);
      wr(OFS_RUN, 32'h04);
      rdw(OFS_COUNT);
      check({31'h0, rd[15:0] > ca + 16'h2}, 32'h1);
      ca = rd[15:0];
   endtask : t_clear

   // software, pin and match captures in every timing mode
   task automatic t_capture;
      cb = ca;
      wr(OFS_MODE, 32'h01);
      rdw(OFS_CAP0);
      check(rd[15:0], cb);
      step(32'h21);
      want_pin_0 <= 1'b1;
      wait_clk(10);
      want_pin_0 <= 1'b0;
      rdw(OFS_CAP0);
      check(rd[15:0], cb);
      step(32'h29);
      want_pin_0 <= 1'b1;
      wait_clk(10);
      rdw(OFS_CAP0);
      check(rd[15:0], ca);
      check(np_rd[15:0], cb);
      want_pin_1 <= 1'b1;
      wait_clk(10);
      rdw(OFS_CAP1);
      check(rd[15:0], ca);
      want_pin_0 <= 1'b0;
      want_pin_1 <= 1'b0;
      step(32'h31);
      want_pin_0 <= 1'b1;
      wait_clk(10);
      rdw(OFS_CAP0);
      check(rd[15:0], ca);
      step(32'h31);
      want_pin_0 <= 1'b0;
      wait_clk(10);
      rdw(OFS_CAP1);
      check(rd[15:0], ca);
      cb = ca;
      step(32'h39);
      want_match <= 16'h0001;
      wait_clk(10);
      want_match <= 16'h0000;
      rdw(OFS_CAP1);
      check(rd[15:0], cb);
      want_match <= 16'h0010;
      wait_clk(10);
      rdw(OFS_CAP0);
      check(rd[15:0], ca);
      step(32'h39);
      want_match <= 16'h0000;
      wait_clk(10);
      rdw(OFS_CAP1);
      check(rd[15:0], ca);
   endtask : t_capture

   // counter clocked by rising edges of pin 0
   task automatic t_extclk;
      step(32'h20);
      wr(OFS_RUN, 32'h05);
      for (int n = 0; n < 5; n++)
      begin
         want_pin_0 <= 1'b1;
         wait_clk(10);
         want_pin_0 <= 1'b0;
         wait_clk(10);
      end
      wr(OFS_RUN, 32'h04);
      rdw(OFS_COUNT);
      check(rd[15:0], ca + 16'h5);
      check(np_rd[15:0], ca);
   endtask : t_extclk

   // main sequence
   initial
   begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_rate();
      t_clear();
      t_capture();
      t_extclk();
      test_done();
   end
endmodule : test_tmcs_top

bind tmcs_top tmcs_top_asserts chk (.aclk, .aresetn, .s_axi_awaddr,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
   .s_axi_rvalid, .s_axi_rready, .match_output);
`default_nettype wire
